// ---- ipvg_top.sv ----
/*
  Interrupt priority ranking and vector address generation with an APB
  register slave for the priority fields and the vector base.
  Assumes request lines come from logic on clk_in, level held until served.
*/
`timescale 1ns/10ps
module ipvg_top
  import ipvg_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b1
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [16:2] irq_req_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output ipvg_win_s winner_out,
  output logic [20:0] vector_fetch_bus_out,
  output logic [20:0] reset_fetch_out,
  output logic [20:0] watchdog_fetch_out
);
  ipvg_apb_req_s req;
  logic [15:0] dbg_prio_q, ext_prio_q;
  logic [`IPVG_VBA_W-1:0] vector_table_base_q;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pslverr_q, pslverr_d;
  logic [`IPVG_IDX_W-1:0] idx;
  logic aligned, wr_en, chk_any;
  logic [1:0] field_a [16:2], fixed_lvl_a [16:2];
  logic fixed_a [16:2], present_a [16:2];
  ipvg_src_s src_a [16:2];
  ipvg_win_s winner_q, winner_d;
  logic [20:0] fetch_q, reset_fetch_q, wdog_fetch_q;
  logic [1:0] chk_max_lvl;

  // Bundle the bus inputs
  assign req = '{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in};

  // Word index decode; upper address bits must be zero
  assign idx = req.paddr[9:2];
  assign aligned = (req.paddr[1:0] == 2'h0) && (req.paddr[11:10] == 2'h0);
  assign wr_en = req.psel & req.penable & pready_q & req.pwrite;

  // Read data and error for the access phase, prepared in setup
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (!aligned)
    begin
      pslverr_d = 1'b1;
    end
    else
    begin
      case (idx)
        `IPVG_IDX_DBG: prdata_d[15:0] = dbg_prio_q;
        `IPVG_IDX_EXT: prdata_d[15:0] = ext_prio_q;
        `IPVG_IDX_STAT:
        begin
          prdata_d[`IPVG_S_VEC +: `IPVG_VEC_W] = winner_q.vector;
          prdata_d[`IPVG_S_LVL +: 2] = winner_q.level;
          prdata_d[`IPVG_S_VALID] = winner_q.valid;
        end
        `IPVG_IDX_VBA: prdata_d[`IPVG_VBA_W-1:0] = vector_table_base_q;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // APB answer: one wait-free access phase after every setup cycle
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= req.psel & ~req.penable;
      prdata_q <= (req.psel & ~req.penable & ~req.pwrite) ?
        prdata_d : 32'h0000_0000;
      pslverr_q <= req.psel & ~req.penable & pslverr_d;
    end
  end
  // Debug source priority fields, disabled after reset
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      dbg_prio_q <= 16'h0000;
    end
    else if (wr_en && aligned && idx == `IPVG_IDX_DBG)
    begin
      dbg_prio_q <= pwdata_in[15:0] & `IPVG_DBG_MASK;
    end
  end
  // Supply detector and clock source priority fields
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ext_prio_q <= 16'h0000;
    end
    else if (wr_en && aligned && idx == `IPVG_IDX_EXT)
    begin
      ext_prio_q <= pwdata_in[15:0] & `IPVG_EXT_MASK;
    end
  end
  // Vector base; the two top bits are not stored
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      vector_table_base_q <= SMALL_VARIANT ? `IPVG_VBA_RST_SMALL
                                           : `IPVG_VBA_RST_LARGE;
    end
    else if (wr_en && aligned && idx == `IPVG_IDX_VBA)
    begin
      vector_table_base_q <= pwdata_in[`IPVG_VBA_W-1:0];
    end
  end

  // Per-vector level source: fixed core levels or programmable fields
  always_comb
  begin
    for (int v = `IPVG_VEC_FIRST; v <= `IPVG_VEC_LAST; v++)
    begin
      field_a[v] = `IPVG_FIELD_OFF;
      fixed_a[v] = 1'b1;
      present_a[v] = 1'b1;
      fixed_lvl_a[v] = `IPVG_LVL_3;
    end
    fixed_lvl_a[11] = `IPVG_LVL_2;
    fixed_lvl_a[12] = `IPVG_LVL_1;
    fixed_lvl_a[13] = `IPVG_LVL_0;
    present_a[14] = 1'b0;
    for (int v = 6; v <= 10; v++)
    begin
      fixed_a[v] = 1'b0;
    end
    fixed_a[15] = 1'b0;
    fixed_a[16] = 1'b0;
    field_a[6] = dbg_prio_q[`IPVG_F_STEP +: 2];
    field_a[7] = dbg_prio_q[`IPVG_F_BKPT +: 2];
    field_a[8] = dbg_prio_q[`IPVG_F_TRACE +: 2];
    field_a[9] = dbg_prio_q[`IPVG_F_TXE +: 2];
    field_a[10] = dbg_prio_q[`IPVG_F_RXF +: 2];
    field_a[15] = ext_prio_q[`IPVG_F_LVI +: 2];
    field_a[16] = ext_prio_q[`IPVG_F_PLL +: 2];
  end

  // One ranking decoder per vector slot
  genvar gv;
  generate
    for (gv = `IPVG_VEC_FIRST; gv <= `IPVG_VEC_LAST; gv++)
    begin : g_src
      ipvg_level_decode u_dec (
        .req_in(irq_req_in[gv]),
        .fixed_in(fixed_a[gv]),
        .present_in(present_a[gv]),
        .fixed_lvl_in(fixed_lvl_a[gv]),
        .field_in(field_a[gv]),
        .src_out(src_a[gv])
      );
    end
  endgenerate

  // Highest level wins; ascending scan keeps the lowest vector on ties
  always_comb
  begin
    winner_d = '0;
    for (int v = `IPVG_VEC_FIRST; v <= `IPVG_VEC_LAST; v++)
    begin
      if (src_a[v].en && (!winner_d.valid ||
          src_a[v].level > winner_d.level))
      begin
        winner_d.valid = 1'b1;
        winner_d.level = src_a[v].level;
        winner_d.vector = `IPVG_VEC_W'(v);
      end
    end
  end

  // Winner and vector addresses, refreshed every cycle
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      winner_q <= '0;
      fetch_q <= 21'h00_0000;
    end
    else
    begin
      winner_q <= winner_d;
      fetch_q <= {vector_table_base_q, 1'b0, winner_d.vector,
                  1'b0};
    end
  end
  // Reset and watchdog targets at the bottom of the table
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      reset_fetch_q <= 21'h00_0000;
      wdog_fetch_q <= 21'h00_0000;
    end
    else
    begin
      reset_fetch_q <= {vector_table_base_q, `IPVG_OFF_RESET};
      wdog_fetch_q <= {vector_table_base_q, `IPVG_OFF_WDOG};
    end
  end

  // Outputs straight from their flops
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign winner_out = winner_q;
  assign vector_fetch_bus_out = fetch_q;
  assign reset_fetch_out = reset_fetch_q;
  assign watchdog_fetch_out = wdog_fetch_q;

  // Independent reference: highest enabled level present
  always_comb
  begin
    chk_max_lvl = 2'h0;
    chk_any = 1'b0;
    for (int v = `IPVG_VEC_FIRST; v <= `IPVG_VEC_LAST; v++)
    begin
      if (src_a[v].en)
      begin
        chk_any = 1'b1;
        if (src_a[v].level > chk_max_lvl)
        begin
          chk_max_lvl = src_a[v].level;
        end
      end
    end
  end

  a_level_first: assert property (
    @(posedge clk_in) disable iff (srst_in)
    $past(chk_any) && !$past(srst_in) |->
      winner_q.valid && winner_q.level == $past(chk_max_lvl))
    else $error("winner is not at the highest pending level");
  a_low_vector: assert property (
    @(posedge clk_in) disable iff (srst_in)
    winner_q.valid && winner_q.vector > 5'h02 && !$past(srst_in) |->
      !($past(src_a[2].en) && $past(src_a[2].level) == winner_q.level))
    else $error("lower vector at same level was passed over");
  a_addr_form: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !$past(srst_in) |->
      vector_fetch_bus_out[20:7] == $past(vector_table_base_q) &&
      vector_fetch_bus_out[6:0] == {1'b0, winner_q.vector, 1'b0})
    else $error("vector address not base plus twice the vector");
  a_reset_slots: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !$past(srst_in) |-> reset_fetch_out[6:0] == `IPVG_OFF_RESET &&
    watchdog_fetch_out[6:0] == `IPVG_OFF_WDOG &&
    !(winner_q.valid && (winner_q.vector == 5'h0e ||
      winner_q.vector < 5'h02)))
    else $error("reset slot offsets wrong or unused slot won");
  a_core_fixed: assert property (
    @(posedge clk_in) disable iff (srst_in)
    $past(irq_req_in[3]) && !$past(srst_in) |->
      winner_q.valid && winner_q.level == `IPVG_LVL_3 &&
      winner_q.vector <= 5'h03)
    else $error("software interrupt 3 not served at level 3");
  a_sw0_alone: assert property (
    @(posedge clk_in) disable iff (srst_in)
    $past(irq_req_in) == 15'h0800 && !$past(srst_in) |->
      winner_q == {1'b1, `IPVG_LVL_0, 5'h0d})
    else $error("software interrupt 0 not served at level 0");
  a_disabled_lose: assert property (
    @(posedge clk_in) disable iff (srst_in)
    $past(dbg_prio_q[`IPVG_F_STEP +: 2]) == `IPVG_FIELD_OFF &&
      !$past(srst_in) |-> !(winner_q.valid && winner_q.vector == 5'h06))
    else $error("disabled step counter source won");
  a_dbg_reset: assert property (
    @(posedge clk_in)
    $past(srst_in) |-> dbg_prio_q == 16'h0000 &&
      ext_prio_q == 16'h0000)
    else $error("priority fields not disabled after reset");
  a_field_map: assert property (
    @(posedge clk_in) disable iff (srst_in)
    $past(wr_en && aligned && idx == `IPVG_IDX_DBG) |->
      field_a[9] == $past(pwdata_in[7:6]) &&
      field_a[8] == $past(pwdata_in[5:4]) &&
      field_a[7] == $past(pwdata_in[3:2]) &&
      field_a[6] == $past(pwdata_in[1:0]))
    else $error("debug priority field in wrong bit position");
  a_base_top_zero: assert property (
    @(posedge clk_in) disable iff (srst_in)
    pready_q && !req.pwrite && $past(aligned && idx == `IPVG_IDX_VBA) |->
      prdata_out[31:14] == 18'h0_0000)
    else $error("vector base top bits not read as zero");
  a_base_reset: assert property (
    @(posedge clk_in)
    $past(srst_in) |-> vector_table_base_q ==
      (SMALL_VARIANT ? `IPVG_VBA_RST_SMALL : `IPVG_VBA_RST_LARGE))
    else $error("vector base reset value wrong for variant");
  a_idle_clear: assert property (
    @(posedge clk_in) disable iff (srst_in)
    $past(irq_req_in) == 15'h0000 && !$past(srst_in) |->
      !winner_q.valid)
    else $error("winner stayed valid with nothing pending");
endmodule

// ---- ipvg_params.svh ----
/*
  Constants for the interrupt priority and vector generator: register
  indexes, field positions, reset values, fixed levels and vector slots.
  Assumes it is included by bare name into the package only; the design sees its macros from there.
*/
`ifndef IPVG_PARAMS_SVH
`define IPVG_PARAMS_SVH

// Register indexes; byte address is four times the index
`define IPVG_IDX_DBG 8'h00
`define IPVG_IDX_EXT 8'h01
`define IPVG_IDX_STAT 8'h02
`define IPVG_IDX_VBA 8'h07
`define IPVG_IDX_W 8

// Debug priority register field positions (low bit of each 2-bit field)
`define IPVG_F_STEP 0
`define IPVG_F_BKPT 2
`define IPVG_F_TRACE 4
`define IPVG_F_TXE 6
`define IPVG_F_RXF 8
`define IPVG_DBG_MASK 16'h03ff

// Supply and clock-source priority register field positions
`define IPVG_F_LVI 0
`define IPVG_F_PLL 2
`define IPVG_EXT_MASK 16'h000f

// Status register field positions
`define IPVG_S_VEC 0
`define IPVG_S_LVL 5
`define IPVG_S_VALID 7

// Vector base reset values for the two variants
`define IPVG_VBA_RST_SMALL 14'h0080
`define IPVG_VBA_RST_LARGE 14'h0000
`define IPVG_VBA_W 14

// Priority field codes and fixed levels
`define IPVG_FIELD_OFF 2'h0
`define IPVG_LVL_3 2'h3
`define IPVG_LVL_2 2'h2
`define IPVG_LVL_1 2'h1
`define IPVG_LVL_0 2'h0

// Vector slots
`define IPVG_VEC_FIRST 2
`define IPVG_VEC_LAST 16
`define IPVG_VEC_W 5
`define IPVG_OFF_RESET 7'h00
`define IPVG_OFF_WDOG 7'h02

`endif

// ---- ipvg_pkg.sv ----
/*
  Types for the interrupt priority and vector generator.
  Assumes ipvg_params.svh is on the include path.
*/
package ipvg_pkg;
  `include "ipvg_params.svh"

  // One ranked request source
  typedef struct packed {
    logic en;
    logic [1:0] level;
  } ipvg_src_s;

  // Current arbitration winner
  typedef struct packed {
    logic valid;
    logic [1:0] level;
    logic [`IPVG_VEC_W-1:0] vector;
  } ipvg_win_s;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ipvg_apb_req_s;
endpackage

// ---- ipvg_level_decode.sv ----
/*
  Ranks one interrupt source: either a fixed level or a 2-bit
  programmable priority field, gated by the pending request.
  Assumes the request is already in the clk_in domain.
*/
`timescale 1ns/10ps
module ipvg_level_decode
  import ipvg_pkg::*;
(
  input wire logic req_in,
  input wire logic fixed_in,
  input wire logic present_in,
  input wire logic [1:0] fixed_lvl_in,
  input wire logic [1:0] field_in,
  output ipvg_src_s src_out
);
  // Code 00 disables, 01..11 are levels 1..3
  always_comb
  begin
    if (fixed_in)
    begin
      src_out.en = req_in & present_in;
      src_out.level = fixed_lvl_in;
    end
    else
    begin
      src_out.en = req_in & (field_in != `IPVG_FIELD_OFF);
      src_out.level = field_in;
    end
  end
endmodule

// ---- ipvg_core_model.sv ----
/*
  Core-side model: turns the presented vector address into a table slot
  and tells which kind of entry the slot holds.
  Assumes fetch and table start come from the generator, same clock.
*/
`timescale 1ns/10ps
module ipvg_core_model
  import ipvg_pkg::*;
(
  input wire logic [20:0] fetch_in,
  input wire logic [20:0] table_in,
  output logic [4:0] slot_out,
  output logic call_out
);
  logic [20:0] off;

  // Slot is the offset from the table start in two-word steps
  always_comb
  begin
    off = fetch_in - table_in;
    slot_out = off[5:1];
    call_out = slot_out > 5'h01; // Jumps in slots 0 and 1, calls elsewhere
  end
endmodule

// ---- interrupt_priority_vector_gen_bench.sv ----
/*
  Self-checking bench for the priority and vector generator.
  Assumes the design package and the core model are compiled first.
*/
`timescale 1ns/10ps
module interrupt_priority_vector_gen_bench
  import ipvg_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [16:2] irq = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ipvg_win_s winner;
  logic [20:0] vfb;
  logic [20:0] rstf;
  logic [20:0] wdf;
  logic [20:0] large_rstf;
  logic [4:0] slot;
  logic call;
  logic [31:0] rdv;
  logic errv;
  logic [13:0] base_m = 14'h0080;
  logic [15:0] dbg_m = '0;
  logic [15:0] ext_m = '0;
  logic [7:0] prev;
  logic [16:2] r;
  int miscompares = 0;
  int cmp_count = 0;

  // Clock at 50 ns period
  always #25 clk_in = ~clk_in;

  ipvg_top i_dut (
    .clk_in(clk_in), .srst_in(srst_in), .irq_req_in(irq),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .winner_out(winner),
    .vector_fetch_bus_out(vfb), .reset_fetch_out(rstf),
    .watchdog_fetch_out(wdf)
  );

  // Large variant, only its reset placement is looked at
  ipvg_top #(.SMALL_VARIANT(1'b0)) i_dut_large (
    .clk_in(clk_in), .srst_in(srst_in), .irq_req_in(irq),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(),
    .pready_out(), .pslverr_out(), .winner_out(),
    .vector_fetch_bus_out(), .reset_fetch_out(large_rstf),
    .watchdog_fetch_out()
  );

  ipvg_core_model i_core (
    .fetch_in(vfb), .table_in(rstf), .slot_out(slot), .call_out(call)
  );

  // Reference arbitration: highest level, then lowest vector
  function automatic logic [7:0] ref_win(input logic [16:2] q,
    input logic [15:0] d, input logic [15:0] e);
    int bl;
    int bv;
    int l;
    bl = -1;
    bv = 0;
    for (int v = 2; v <= 16; v++)
    begin
      if (v <= 5) l = 3;
      else if (v <= 10) l = (d >> (2 * (v - 6))) & 3;
      else if (v <= 13) l = 13 - v;
      else if (v == 14) l = -1;
      else l = (e >> (2 * (v - 15))) & 3;
      if (l == 0 && v != 13) l = -1;
      if (q[v] && l > bl)
      begin
        bl = l;
        bv = v;
      end
    end
    return (bl < 0) ? 8'h00 : {1'b1, 2'(bl), 5'(bv)};
  endfunction

  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    // Sample pready at each rising edge; data taken at that same edge
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      tally_and_finish();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Programs all priority fields and the base in bench and model
  task automatic setup(input logic [31:0] d, input logic [31:0] e,
    input logic [31:0] b);
    apb(1'b1, 12'h000, d);
    dbg_m = d[15:0] & 16'h03ff;
    apb(1'b1, 12'h004, e);
    ext_m = e[15:0] & 16'h000f;
    apb(1'b1, 12'h01c, b);
    base_m = b[13:0];
  endtask

  // Applies a request set and compares the answer one cycle on
  task automatic step(input logic [16:2] q);
    logic [7:0] e;
    e = ref_win(q, dbg_m, ext_m);
    @(posedge clk_in);
    irq <= q;
    @(posedge clk_in);
    #1;
    check(winner, e);
    check(vfb, {base_m, e[7] ? {1'b0, e[4:0], 1'b0} : 7'h00});
    check(slot, e[7] ? e[4:0] : 5'h00);
    check(call, e[7]);
    check(rstf, {base_m, 7'h00});
    check(wdf, {base_m, 7'h02});
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(53461));
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check(rstf, 21'h00_4000);
    check(wdf, 21'h00_4002);
    check(large_rstf, 21'h00_0000);
    apb(1'b0, 12'h01c, 32'h0000_0000);
    check(rdv, 32'h0000_0080);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rdv, 32'h0000_0000);
    setup(32'hffff_ffff, 32'hffff_ffff, 32'h0000_ffff);
    apb(1'b0, 12'h01c, 32'h0000_0000);
    check(rdv, 32'h0000_3fff);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rdv, 32'h0000_03ff);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    check({rdv[30:0], errv}, 32'h0000_0001);
    apb(1'b1, 12'h01d, 32'h0000_0000);
    check(errv, 1'b1);
    // Directed sets: lone level 0 call, unused slot, nothing pending
    step(15'h0800);
    step(15'h1000);
    step(15'h0000);
    // Each debug field alone, every code, beside a level 0 request
    for (int f = 0; f < 5; f++)
      for (int c = 0; c < 4; c++)
      begin
        setup(c << (2 * f), 32'h0000_0000, 32'h0000_1234);
        step(15'(1 << (6 + f - 2)) | 15'(1 << 11));
      end
    // Random programming and requests, status read, per-cycle changes
    for (int i = 0; i < 150; i++)
    begin
      setup($urandom(), $urandom(), $urandom() & 32'h0000_3fff);
      r = 15'($urandom());
      step(r);
      apb(1'b0, 12'h008, 32'h0000_0000);
      check(rdv, {24'h00_0000, ref_win(r, dbg_m, ext_m)});
      for (int k = 0; k < 6; k++)
      begin
        @(posedge clk_in);
        r = 15'($urandom() & $urandom());
        irq <= r;
        #1;
        if (k > 0) check(winner, prev);
        prev = ref_win(r, dbg_m, ext_m);
      end
    end
    // Reset again in mid-run: fields and base return to reset values
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    apb(1'b0, 12'h01c, 32'h0000_0000);
    check(rdv, 32'h0000_0080);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rdv, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
